// ---- hdl/msp_map.vh ----
// constants of the modbus serial slave port: parameter numbers, codes, reset values
//
// Overview of operation
// - bit rate code 1..6 selects 2400..115200 baud
// - parity code: 0 even, 1 odd, 2 none
// - new rate or parity waits for reset
// - writing 123 to parameter 34 resets softly
// - node address 1..247, defaults to 1
// - node address change matches at once
// - protocol code 2 rtu, 3 ascii framing
// - protocol resets to 0, modbus then ignored
// - protocol change switches handling immediately
// - slave never transmits unrequested
// - frames from other slaves are not requests
// - own address request gets exactly one response
// - address 0 is broadcast, no response
// - broadcast writes are accepted and executed
// - errored request: send nothing, await next
`ifndef MSP_MAP_VH
`define MSP_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// parameter numbers on the parameter port
`define MSP_PAR_BAUD      16'h000a
`define MSP_PAR_PROG      16'h0022
`define MSP_PAR_PROTO     16'h018b
`define MSP_PAR_PARITY    16'h055f
`define MSP_PAR_ADDR      16'h0560

// reset values and legal limits
`define MSP_BAUD_RST      16'h0004
`define MSP_PARITY_RST    16'h0000
`define MSP_PROTO_RST     16'h0000
`define MSP_ADDR_RST      16'h0001
`define MSP_PROG_RST      16'h0000
`define MSP_SOFT_RST_KEY  16'h007b
`define MSP_BAUD_MIN      16'h0001
`define MSP_BAUD_MAX      16'h0006
`define MSP_PARITY_MAX    16'h0002
`define MSP_PROTO_MAX     16'h0003
`define MSP_ADDR_MIN      16'h0001
`define MSP_ADDR_MAX      16'h00f7
`define MSP_ADDR_BCAST    8'h00

// codes
`define MSP_PROTO_RTU     16'h0002
`define MSP_PROTO_ASCII   16'h0003
`define MSP_PAR_EVEN      2'h0
`define MSP_PAR_ODD       2'h1
`define MSP_PAR_NONE      2'h2

// timing: clock rate and bit rates, in hertz
`define MSP_CLK_HZ        20000000
`define MSP_RATE_1        2400
`define MSP_RATE_2        4800
`define MSP_RATE_3        9600
`define MSP_RATE_4        19200
`define MSP_RATE_5        57600
`define MSP_RATE_6        115200
`define MSP_DIV(r)        ((`MSP_CLK_HZ + (r) / 2) / (r))
// silent bit times closing an rtu frame: 3.5 characters of 11 bits
`define MSP_GAP_BITS      6'h27

// ascii framing characters and fifo word layout
`define MSP_ASC_START     8'h3a
`define MSP_ASC_END       8'h0a
`define MSP_W_MARK        9
`define MSP_W_GOOD        8

`endif

// ---- hdl/msp_fifo.v ----
// request fifo with registered read data between the framer and the application
`timescale 1ns/1ps
module msp_fifo #(
	parameter W     = 10,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire         clk_i,
	input  wire         rst_b_i,
	input  wire         clr_i,
	input  wire [W-1:0] in_data_i,
	input  wire         in_valid_i,
	output wire         in_ready_o,
	output reg  [W-1:0] out_data_o,
	output reg          out_valid_o,
	input  wire         out_ready_i
);
	reg [W-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wptr_reg;
	reg [AW-1:0] rptr_reg;
	reg [AW:0]   count_reg;
	wire         push;
	wire         pop;

	// full counts only the array; the output register holds one word more
	assign in_ready_o = (count_reg != DEPTH[AW:0]);
	assign push       = in_valid_i & in_ready_o;
	assign pop        = (count_reg != {(AW+1){1'b0}}) & (~out_valid_o | out_ready_i);

	// storage array, written without reset
	always @(posedge clk_i) begin
		if (push) begin
			mem[wptr_reg] <= in_data_i;
		end
	end

	// pointers, fill level and output stage
	always @(posedge clk_i) begin
		if (!rst_b_i || clr_i) begin
			wptr_reg    <= {AW{1'b0}};
			rptr_reg    <= {AW{1'b0}};
			count_reg   <= {(AW+1){1'b0}};
			out_valid_o <= 1'b0;
			out_data_o  <= {W{1'b0}};
		end else begin
			if (push) begin
				wptr_reg <= wptr_reg + 1'b1;
			end
			if (pop) begin
				rptr_reg    <= rptr_reg + 1'b1;
				out_data_o  <= mem[rptr_reg];
				out_valid_o <= 1'b1;
			end else if (out_ready_i) begin
				out_valid_o <= 1'b0;
			end
			count_reg <= count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end
endmodule

// ---- hdl/msp_char.v ----
// serial character engine: receive and send one character, detect line silence
`timescale 1ns/1ps
`include "msp_map.vh"
module msp_char #(
	parameter DIV_W = 14
) (
	input  wire             clk_i,
	input  wire             rst_b_i,
	input  wire             clr_i,
	input  wire [DIV_W-1:0] div_i,
	input  wire [1:0]       par_mode_i,
	input  wire             seven_i,
	input  wire             rx_i,
	output reg  [7:0]       rx_data_o,
	output reg              rx_stb_o,
	output reg              rx_err_o,
	output reg              gap_o,
	input  wire [7:0]       tx_data_i,
	input  wire             tx_go_i,
	output reg              tx_busy_o,
	output reg              tx_o,
	output reg              tx_en_o
);
	localparam RX_IDLE = 3'h0, RX_START = 3'h1, RX_DATA = 3'h2, RX_PAR = 3'h3, RX_STOP = 3'h4;

	reg [2:0]       rx_st_reg;
	reg [DIV_W-1:0] rx_cnt_reg;
	reg [2:0]       rx_idx_reg;
	reg [7:0]       rx_sh_reg;
	reg             rx_acc_reg;
	reg             rx_bad_reg;
	reg [DIV_W-1:0] gap_cnt_reg;
	reg [5:0]       gap_bits_reg;
	reg [12:0]      tx_sh_reg;
	reg [3:0]       tx_n_reg;
	reg [DIV_W-1:0] tx_cnt_reg;
	wire            par_on;
	wire [2:0]      last_idx;
	wire [8:0]      tx_body;
	wire            tx_par;

	assign par_on   = (par_mode_i != `MSP_PAR_NONE);
	assign last_idx = seven_i ? 3'h6 : 3'h7;
	// even parity makes the ones count even, odd makes it odd
	assign tx_par   = (seven_i ? ^tx_data_i[6:0] : ^tx_data_i) ^ (par_mode_i == `MSP_PAR_ODD);
	// no parity is replaced by a second stop bit so the character length stays fixed
	assign tx_body  = seven_i ? (par_on ? {1'b1, tx_par, tx_data_i[6:0]} : {2'b11, tx_data_i[6:0]})
	                          : (par_on ? {tx_par, tx_data_i} : {1'b1, tx_data_i});

	// receiver: mid-bit sampling, parity and stop checks
	always @(posedge clk_i) begin
		if (!rst_b_i || clr_i) begin
			rx_st_reg  <= RX_IDLE;
			rx_cnt_reg <= {DIV_W{1'b0}};
			rx_idx_reg <= 3'h0;
			rx_sh_reg  <= 8'h00;
			rx_acc_reg <= 1'b0;
			rx_bad_reg <= 1'b0;
			rx_data_o  <= 8'h00;
			rx_stb_o   <= 1'b0;
			rx_err_o   <= 1'b0;
		end else begin
			rx_stb_o <= 1'b0;
			if (rx_st_reg != RX_IDLE) begin
				rx_cnt_reg <= rx_cnt_reg - 1'b1;
			end
			case (rx_st_reg)
			RX_IDLE: begin
				if (!rx_i) begin
					rx_cnt_reg <= div_i >> 1;
					rx_st_reg  <= RX_START;
				end
			end
			RX_START: begin
				if (rx_cnt_reg == {DIV_W{1'b0}}) begin
					rx_cnt_reg <= div_i - 1'b1;
					rx_idx_reg <= 3'h0;
					rx_acc_reg <= 1'b0;
					rx_bad_reg <= 1'b0;
					rx_st_reg  <= rx_i ? RX_IDLE : RX_DATA; // glitch shorter than half a bit
				end
			end
			RX_DATA: begin
				if (rx_cnt_reg == {DIV_W{1'b0}}) begin
					rx_cnt_reg <= div_i - 1'b1;
					rx_sh_reg  <= {rx_i, rx_sh_reg[7:1]};
					rx_acc_reg <= rx_acc_reg ^ rx_i;
					rx_idx_reg <= rx_idx_reg + 1'b1;
					if (rx_idx_reg == last_idx) begin
						rx_st_reg <= par_on ? RX_PAR : RX_STOP;
					end
				end
			end
			RX_PAR: begin
				if (rx_cnt_reg == {DIV_W{1'b0}}) begin
					rx_cnt_reg <= div_i - 1'b1;
					rx_bad_reg <= (rx_acc_reg ^ rx_i) != (par_mode_i == `MSP_PAR_ODD);
					rx_st_reg  <= RX_STOP;
				end
			end
			default: begin
				if (rx_cnt_reg == {DIV_W{1'b0}}) begin
					rx_data_o <= seven_i ? {1'b0, rx_sh_reg[7:1]} : rx_sh_reg;
					rx_err_o  <= rx_bad_reg | ~rx_i; // framing error on a low stop bit
					rx_stb_o  <= 1'b1;
					rx_st_reg <= RX_IDLE;
				end
			end
			endcase
		end
	end

	// silence detector: one pulse after the gap, then quiet until the next start bit
	always @(posedge clk_i) begin
		if (!rst_b_i || clr_i) begin
			gap_cnt_reg  <= {DIV_W{1'b0}};
			gap_bits_reg <= 6'h00;
			gap_o        <= 1'b0;
		end else begin
			gap_o <= 1'b0;
			if (rx_st_reg != RX_IDLE || !rx_i) begin
				gap_cnt_reg  <= {DIV_W{1'b0}};
				gap_bits_reg <= 6'h00;
			end else if (gap_bits_reg <= `MSP_GAP_BITS) begin
				if (gap_cnt_reg == div_i - 1'b1) begin
					gap_cnt_reg  <= {DIV_W{1'b0}};
					gap_bits_reg <= gap_bits_reg + 1'b1;
					gap_o        <= (gap_bits_reg == `MSP_GAP_BITS - 1'b1);
				end else begin
					gap_cnt_reg <= gap_cnt_reg + 1'b1;
				end
			end
		end
	end

	// transmitter: 13-bit shift register, line driver enabled for the whole character
	always @(posedge clk_i) begin
		if (!rst_b_i || clr_i) begin
			tx_sh_reg  <= 13'h1fff;
			tx_n_reg   <= 4'h0;
			tx_cnt_reg <= {DIV_W{1'b0}};
			tx_busy_o  <= 1'b0;
			tx_o       <= 1'b1;
			tx_en_o    <= 1'b0;
		end else if (!tx_busy_o) begin
			tx_o    <= 1'b1;
			tx_en_o <= 1'b0;
			if (tx_go_i) begin
				tx_sh_reg  <= {3'b111, tx_body, 1'b0};
				tx_n_reg   <= seven_i ? 4'ha : 4'hb;
				tx_cnt_reg <= {DIV_W{1'b0}};
				tx_busy_o  <= 1'b1;
			end
		end else if (tx_cnt_reg == {DIV_W{1'b0}}) begin
			if (tx_n_reg == 4'h0) begin
				tx_busy_o <= 1'b0;
				tx_en_o   <= 1'b0;
				tx_o      <= 1'b1;
			end else begin
				tx_o       <= tx_sh_reg[0];
				tx_en_o    <= 1'b1;
				tx_sh_reg  <= {1'b1, tx_sh_reg[12:1]};
				tx_n_reg   <= tx_n_reg - 1'b1;
				tx_cnt_reg <= div_i - 1'b1;
			end
		end else begin
			tx_cnt_reg <= tx_cnt_reg - 1'b1;
		end
	end
endmodule

// ---- hdl/msp_port.v ----
// modbus serial slave port: parameters, request framing, address filter, reply gate
`timescale 1ns/1ps
`include "msp_map.vh"
module msp_port #(
	parameter DIV_W    = 14,
	parameter DIV_2400 = `MSP_DIV(`MSP_RATE_1),
	parameter DIV_4800 = `MSP_DIV(`MSP_RATE_2),
	parameter FIFO_D   = 16,
	parameter FIFO_AW  = 4
) (
	input  wire        clk_i,
	input  wire        rst_b_i,
	input  wire        rx_i,
	output wire        tx_o,
	output wire        tx_en_o,
	input  wire        par_we_i,
	input  wire [15:0] par_num_i,
	input  wire [15:0] par_wdata_i,
	output reg  [15:0] par_rdata_o,
	output reg         par_err_o,
	output wire [7:0]  req_data_o,
	output wire        req_end_o,
	output wire        req_good_o,
	output wire        req_valid_o,
	input  wire        req_ready_i,
	input  wire [7:0]  resp_data_i,
	input  wire        resp_last_i,
	input  wire        resp_valid_i,
	output reg         resp_ready_o,
	output reg         resp_pending_o,
	output reg         modbus_on_o
);
	localparam F_IDLE = 3'h0, F_ADDR = 3'h1, F_ALO = 3'h2, F_BODY = 3'h3, F_SKIP = 3'h4;
	localparam FW = 10;
	localparam DIV_9600  = `MSP_DIV(`MSP_RATE_3), DIV_19200  = `MSP_DIV(`MSP_RATE_4);
	localparam DIV_57600 = `MSP_DIV(`MSP_RATE_5), DIV_115200 = `MSP_DIV(`MSP_RATE_6);

	reg [15:0]      baud_reg;
	reg [15:0]      prog_reg;
	reg [15:0]      proto_reg;
	reg [15:0]      parity_reg;
	reg [15:0]      addr_reg;
	reg [DIV_W-1:0] act_div_reg;
	reg [1:0]       act_par_reg;
	reg             soft_rst_reg;
	reg [2:0]       fst_reg;
	reg [3:0]       asc_hi_reg;
	reg [7:0]       hi_chr_reg;
	reg             lo_pend_reg;
	reg [7:0]       lo_chr_reg;
	reg             bcast_reg;
	reg             ferr_reg;
	reg             tx_go_reg;
	reg [7:0]       tx_byte_reg;
	reg             push;
	reg [FW-1:0]    push_word;
	reg [15:0]      rd_next;
	reg             rd_err_next;
	wire            is_modbus;
	wire            is_rtu;
	wire [7:0]      rx_data;
	wire            rx_stb;
	wire            rx_err;
	wire            gap;
	wire            tx_busy;
	wire            fifo_ready;
	wire [FW-1:0]   fifo_out;
	wire            take;
	wire [4:0]      hex_lo;
	wire [7:0]      asc_addr;

	// bit period in clock cycles for a rate code; faster rates fit below the parameter
	function [DIV_W-1:0] rate_div;
		input [15:0] code;
		begin
			if (code == 16'h0001)
				rate_div = DIV_2400[DIV_W-1:0];
			else if (code == 16'h0002)
				rate_div = DIV_4800[DIV_W-1:0];
			else if (code == 16'h0003)
				rate_div = DIV_9600[DIV_W-1:0];
			else if (code == 16'h0005)
				rate_div = DIV_57600[DIV_W-1:0];
			else if (code == 16'h0006)
				rate_div = DIV_115200[DIV_W-1:0];
			else
				rate_div = DIV_19200[DIV_W-1:0];
		end
	endfunction

	// ascii hex digit to {valid, nibble}
	function [4:0] hex_val;
		input [7:0] c;
		begin
			if (c >= 8'h30 && c <= 8'h39)
				hex_val = {1'b1, c[3:0]};
			else if (c >= 8'h41 && c <= 8'h46)
				hex_val = {1'b1, c[3:0] + 4'h9};
			else if (c >= 8'h61 && c <= 8'h66)
				hex_val = {1'b1, c[3:0] + 4'h9};
			else
				hex_val = 5'h00;
		end
	endfunction

	assign is_modbus = (proto_reg == `MSP_PROTO_RTU) || (proto_reg == `MSP_PROTO_ASCII);
	assign is_rtu    = (proto_reg == `MSP_PROTO_RTU);
	assign hex_lo    = hex_val(rx_data);
	assign asc_addr  = {asc_hi_reg, hex_lo[3:0]};
	assign req_data_o = fifo_out[7:0];
	assign req_end_o  = fifo_out[`MSP_W_MARK];
	assign req_good_o = fifo_out[`MSP_W_GOOD];
	assign take       = resp_valid_i & resp_ready_o;

	////////////////////////////////////////////////////////////////////////////////
	// parameter store; writes outside the legal range are refused without raising par_err_o
	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			baud_reg     <= `MSP_BAUD_RST;
			prog_reg     <= `MSP_PROG_RST;
			proto_reg    <= `MSP_PROTO_RST;
			parity_reg   <= `MSP_PARITY_RST;
			addr_reg     <= `MSP_ADDR_RST;
			soft_rst_reg <= 1'b0;
		end else begin
			soft_rst_reg <= 1'b0;
			if (par_we_i) begin
				if (par_num_i == `MSP_PAR_BAUD) begin
					if (par_wdata_i >= `MSP_BAUD_MIN && par_wdata_i <= `MSP_BAUD_MAX)
						baud_reg <= par_wdata_i;
				end else if (par_num_i == `MSP_PAR_PROG) begin
					prog_reg     <= par_wdata_i;
					soft_rst_reg <= (par_wdata_i == `MSP_SOFT_RST_KEY);
				end else if (par_num_i == `MSP_PAR_PROTO) begin
					if (par_wdata_i <= `MSP_PROTO_MAX)
						proto_reg <= par_wdata_i;
				end else if (par_num_i == `MSP_PAR_PARITY) begin
					if (par_wdata_i <= `MSP_PARITY_MAX)
						parity_reg <= par_wdata_i;
				end else if (par_num_i == `MSP_PAR_ADDR) begin
					if (par_wdata_i >= `MSP_ADDR_MIN && par_wdata_i <= `MSP_ADDR_MAX)
						addr_reg <= par_wdata_i;
				end
			end
		end
	end

	// read-back decode, registered so the read port comes straight from flops
	always @* begin
		rd_err_next = 1'b0;
		rd_next     = 16'h0000;
		if (par_num_i == `MSP_PAR_BAUD)
			rd_next = baud_reg;
		else if (par_num_i == `MSP_PAR_PROG)
			rd_next = prog_reg;
		else if (par_num_i == `MSP_PAR_PROTO)
			rd_next = proto_reg;
		else if (par_num_i == `MSP_PAR_PARITY)
			rd_next = parity_reg;
		else if (par_num_i == `MSP_PAR_ADDR)
			rd_next = addr_reg;
		else
			rd_err_next = 1'b1;
	end

	// the running bit rate and parity only change at reset, never on the write itself
	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			act_div_reg <= rate_div(`MSP_BAUD_RST);
			act_par_reg <= `MSP_PAR_EVEN; // reset line format is even parity
			par_rdata_o <= 16'h0000;
			par_err_o   <= 1'b0;
			modbus_on_o <= 1'b0;
		end else begin
			if (soft_rst_reg) begin
				act_div_reg <= rate_div(baud_reg);
				act_par_reg <= parity_reg[1:0];
			end
			par_rdata_o <= rd_next;
			par_err_o   <= par_we_i ? 1'b0 : rd_err_next;
			modbus_on_o <= is_modbus;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// character engine; rtu uses 8 data bits, ascii 7
	msp_char #(
		.DIV_W      (DIV_W)
	) u_char (
		.clk_i      (clk_i),
		.rst_b_i    (rst_b_i),
		.clr_i      (soft_rst_reg),
		.div_i      (act_div_reg),
		.par_mode_i (act_par_reg),
		.seven_i    (~is_rtu),
		.rx_i       (rx_i),
		.rx_data_o  (rx_data),
		.rx_stb_o   (rx_stb),
		.rx_err_o   (rx_err),
		.gap_o      (gap),
		.tx_data_i  (tx_byte_reg),
		.tx_go_i    (tx_go_reg),
		.tx_busy_o  (tx_busy),
		.tx_o       (tx_o),
		.tx_en_o    (tx_en_o)
	);

	// request fifo; a full fifo spoils the frame since the serial line cannot stall
	msp_fifo #(
		.W           (FW),
		.DEPTH       (FIFO_D),
		.AW          (FIFO_AW)
	) u_fifo (
		.clk_i       (clk_i),
		.rst_b_i     (rst_b_i),
		.clr_i       (soft_rst_reg),
		.in_data_i   (push_word),
		.in_valid_i  (push),
		.in_ready_o  (fifo_ready),
		.out_data_o  (fifo_out),
		.out_valid_o (req_valid_o),
		.out_ready_i (req_ready_i)
	);

	////////////////////////////////////////////////////////////////////////////////
	// what the framer writes into the fifo this cycle
	always @* begin
		push      = 1'b0;
		push_word = {FW{1'b0}};
		if (lo_pend_reg) begin
			push      = 1'b1;
			push_word = {2'b00, lo_chr_reg};
		end else if (is_modbus && fst_reg == F_BODY) begin
			if (is_rtu && gap) begin
				push      = 1'b1;
				push_word = {1'b1, ~ferr_reg, 7'h00, bcast_reg};
			end else if (!is_rtu && rx_stb && rx_data == `MSP_ASC_START) begin
				push      = 1'b1;
				push_word = {2'b10, 7'h00, bcast_reg}; // frame cut short, reported bad
			end else if (!is_rtu && rx_stb && rx_data == `MSP_ASC_END) begin
				push      = 1'b1;
				push_word = {1'b1, ~(ferr_reg | rx_err), 7'h00, bcast_reg};
			end else if (rx_stb) begin
				push      = 1'b1;
				push_word = {2'b00, rx_data};
			end
		end else if (is_modbus && fst_reg == F_IDLE && is_rtu && rx_stb && !rx_err) begin
			if (rx_data == addr_reg[7:0] || rx_data == `MSP_ADDR_BCAST) begin
				push      = 1'b1;
				push_word = {2'b00, rx_data};
			end
		end else if (is_modbus && fst_reg == F_ALO && rx_stb && hex_lo[4] && !rx_err) begin
			if (asc_addr == addr_reg[7:0] || asc_addr == `MSP_ADDR_BCAST) begin
				push      = 1'b1;
				push_word = {2'b00, hi_chr_reg};
			end
		end
	end

	// frame state: address filter and frame bounds for rtu and ascii
	always @(posedge clk_i) begin
		if (!rst_b_i || soft_rst_reg) begin
			fst_reg     <= F_SKIP; // resync on the first gap or start character
			asc_hi_reg  <= 4'h0;
			hi_chr_reg  <= 8'h00;
			lo_pend_reg <= 1'b0;
			lo_chr_reg  <= 8'h00;
			bcast_reg   <= 1'b0;
			ferr_reg    <= 1'b0;
		end else if (!is_modbus) begin
			fst_reg     <= F_SKIP;
			lo_pend_reg <= 1'b0;
		end else begin
			lo_pend_reg <= 1'b0;
			case (fst_reg)
			F_IDLE: begin
				if (!is_rtu) begin
					fst_reg <= F_SKIP;
				end else if (rx_stb) begin
					ferr_reg  <= 1'b0;
					bcast_reg <= (rx_data == `MSP_ADDR_BCAST);
					if (rx_err)
						fst_reg <= F_SKIP;
					else if (rx_data == addr_reg[7:0] || rx_data == `MSP_ADDR_BCAST)
						fst_reg <= F_BODY;
					else
						fst_reg <= F_SKIP;
				end
			end
			F_ADDR: begin
				if (rx_stb) begin
					hi_chr_reg <= rx_data;
					asc_hi_reg <= hex_lo[3:0];
					fst_reg    <= (hex_lo[4] && !rx_err) ? F_ALO : F_SKIP;
				end
			end
			F_ALO: begin
				if (rx_stb) begin
					ferr_reg   <= 1'b0;
					bcast_reg  <= (asc_addr == `MSP_ADDR_BCAST);
					lo_chr_reg <= rx_data;
					if (push) begin
						lo_pend_reg <= 1'b1;
						fst_reg     <= F_BODY;
					end else begin
						fst_reg <= F_SKIP;
					end
				end
			end
			F_BODY: begin
				if (rx_stb && rx_err)
					ferr_reg <= 1'b1;
				if (is_rtu && gap)
					fst_reg <= F_IDLE;
				else if (!is_rtu && rx_stb && rx_data == `MSP_ASC_START)
					fst_reg <= F_ADDR;
				else if (!is_rtu && rx_stb && rx_data == `MSP_ASC_END)
					fst_reg <= F_SKIP;
			end
			default: begin
				if (is_rtu && gap)
					fst_reg <= F_IDLE;
				else if (!is_rtu && rx_stb && rx_data == `MSP_ASC_START)
					fst_reg <= F_ADDR;
			end
			endcase
			// after the case so an overflow on the address byte beats its clear
			if (push && !fifo_ready)
				ferr_reg <= 1'b1; // overflow counts as a communication error
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// reply gate: one response per good unicast request; otherwise replies are sunk
	always @(posedge clk_i) begin
		if (!rst_b_i || soft_rst_reg) begin
			resp_pending_o <= 1'b0;
			resp_ready_o   <= 1'b0;
			tx_go_reg      <= 1'b0;
			tx_byte_reg    <= 8'h00;
		end else begin
			tx_go_reg <= 1'b0;
			if (push && push_word[`MSP_W_MARK] && push_word[`MSP_W_GOOD] && fifo_ready
			    && !bcast_reg) begin
				resp_pending_o <= 1'b1;
			end else if (take && resp_pending_o && resp_last_i) begin
				resp_pending_o <= 1'b0;
			end
			if (take && resp_pending_o) begin
				tx_go_reg   <= 1'b1;
				tx_byte_reg <= resp_data_i;
			end
			// one byte at a time while a reply is owed; the master waits
			resp_ready_o <= ~resp_pending_o | (~take & ~tx_go_reg & ~tx_busy & ~resp_ready_o);
		end
	end
endmodule

// ---- dv/msp_port_checker.sv ----
// assertions on the ports of the modbus serial slave port
`timescale 1ns/1ps
module msp_port_checker (
	input wire        clk_i,
	input wire        rst_b_i,
	input wire        tx_o,
	input wire        tx_en_o,
	input wire        par_we_i,
	input wire [15:0] par_num_i,
	input wire [15:0] par_wdata_i,
	input wire [15:0] par_rdata_o,
	input wire [7:0]  req_data_o,
	input wire        req_end_o,
	input wire        req_good_o,
	input wire        req_valid_o,
	input wire        resp_valid_i,
	input wire        resp_ready_o,
	input wire        resp_pending_o,
	input wire        modbus_on_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	// end-of-frame word on the request stream
	wire marker = req_valid_o && req_end_o;

	a_tx_idle: assert property (!tx_en_o |-> tx_o)
		else $error("line low while driver off");
	a_no_unsolicited: assert property ($rose(tx_en_o) |-> $past(resp_pending_o, 3))
		else $error("character sent without a request");
	a_start_low: assert property ($rose(tx_en_o) |-> !tx_o [*8])
		else $error("start bit missing");
	a_reply_go: assert property (resp_valid_i && resp_ready_o && resp_pending_o
		|=> !resp_ready_o ##2 (tx_en_o && !tx_o)) else $error("reply byte not sent");
	a_sink_quiet: assert property (resp_valid_i && resp_ready_o && !resp_pending_o
		|=> resp_ready_o && !tx_en_o) else $error("unowed reply sent");
	a_proto_now: assert property (par_we_i && par_num_i == 16'h018b && par_wdata_i <= 16'h0003
		|-> ##2 modbus_on_o == $past(par_wdata_i[1], 2)) else $error("protocol not switched");
	a_addr_range: assert property (!par_we_i && par_num_i == 16'h0560
		|=> par_rdata_o >= 16'h0001 && par_rdata_o <= 16'h00f7) else $error("address out of range");
	a_bcast_quiet: assert property (marker && req_data_o[0] |-> !resp_pending_o)
		else $error("broadcast owes a reply");
	a_bad_quiet: assert property (marker && !req_good_o |-> !resp_pending_o)
		else $error("errored frame owes a reply");

	c_unicast: cover property (marker && req_good_o && !req_data_o[0]);
	c_bcast: cover property (marker && req_data_o[0]);
	c_reply: cover property ($rose(tx_en_o));
endmodule
bind msp_port msp_port_checker msp_port_checker_inst (.*);

// ---- dv/msp_port_master.sv ----
// bus master model: sends request characters and decodes reply characters
`timescale 1ns/1ps
module msp_port_master (
	input  wire       tx_i,
	input  wire       tx_en_i,
	output reg        rx_o,
	output reg  [7:0] last_o,
	output reg  [7:0] cnt_o
);
	localparam time BT = 8700; // 174 clocks, same rate as the slave
	integer i;
	initial begin
		rx_o = 1;
		cnt_o = 0;
		last_o = 0;
	end
	// start, eight data lsb first, even parity (bad flips it), stop
	task send(input [7:0] d, input bad);
		integer k;
		rx_o = 0;
		#BT;
		for (k = 0; k < 8; k++) begin
			rx_o = d[k];
			#BT;
		end
		rx_o = ^d ^ bad;
		#BT;
		rx_o = 1;
		#BT;
	endtask
	// seven data bits, even parity: the eighth bit carries parity, the ninth idles high
	task send7(input [6:0] c);
		send({^c, c}, 1'b1);
	endtask
	// the bench calls this only once the previous reply is over
	task frame(input [7:0] a, input [7:0] f, input bad);
		send(a, 1'b0);
		send(f, bad);
	endtask
	// decode each reply character at mid bit; parity is not judged here
	always @(posedge tx_en_i) begin
		#(BT / 2);
		for (i = 0; i < 8; i++) begin
			#BT;
			last_o[i] = tx_i;
		end
		cnt_o = cnt_o + 1;
	end
endmodule

// ---- dv/msp_port_tb_top.sv ----
// self-checking bench of the modbus serial slave port
`timescale 1ns/1ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin mismatches++; \
	$display("MISMATCH %s expected %h seen %h", n, e, s); end end
module msp_port_tb_top;
	reg         clk_i = 0;
	reg         rst_b_i = 0;
	reg         par_we_i = 0;
	reg  [15:0] par_num_i = 0;
	reg  [15:0] par_wdata_i = 0;
	reg         req_ready_i = 1;
	reg  [7:0]  resp_data_i = 0;
	reg         resp_last_i = 0;
	reg         resp_valid_i = 0;
	wire        rx_i, tx_o, tx_en_o, par_err_o, req_end_o, req_good_o, req_valid_o;
	wire        resp_ready_o, resp_pending_o, modbus_on_o;
	wire [15:0] par_rdata_o;
	wire [7:0]  req_data_o, last_byte, char_cnt;
	integer     mismatches = 0;
	integer     samples_checked = 0;
	reg  [9:0]  q[$];

	msp_port msp_port_inst (.*);
	msp_port_master msp_port_master_inst (.tx_i(tx_o), .tx_en_i(tx_en_o), .rx_o(rx_i),
		.last_o(last_byte), .cnt_o(char_cnt));
	initial forever #25 clk_i = ~clk_i;
	// collect request words as {end, good, data}
	always @(posedge clk_i) if (req_valid_o && req_ready_i) q.push_back({req_end_o, req_good_o, req_data_o});

	task summarize;
		if (mismatches == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task wr(input [15:0] n, input [15:0] v);
		@(negedge clk_i);
		par_we_i = 1;
		par_num_i = n;
		par_wdata_i = v;
		@(negedge clk_i);
		par_we_i = 0;
	endtask
	task rd(input [15:0] n, input [15:0] v);
		@(negedge clk_i);
		par_num_i = n;
		@(negedge clk_i);
		`CHK("par_rdata_o", v, par_rdata_o)
	endtask
	// send a frame, then wait past the 39 bit silence that closes it
	task req(input [7:0] a, input bad);
		q.delete();
		msp_port_master_inst.frame(a, 8'h06, bad);
		repeat (45 * 174) @(negedge clk_i);
	endtask
	// offer one reply byte and hold it until taken
	task reply(input [7:0] d, input last);
		integer i;
		@(negedge clk_i);
		resp_valid_i = 1;
		resp_data_i = d;
		resp_last_i = last;
		for (i = 0; i < 4000 && resp_ready_o !== 1'b1; i++) @(negedge clk_i);
		if (resp_ready_o !== 1'b1) begin
			mismatches++;
			summarize;
		end
		@(negedge clk_i);
		resp_valid_i = 0;
	endtask

	task t_regs;
		rd(16'h000a, 16'h0004);
		rd(16'h055f, 16'h0000);
		rd(16'h018b, 16'h0000);
		rd(16'h0560, 16'h0001);
		wr(16'h0560, 16'h00f8);
		rd(16'h0560, 16'h0001);
		wr(16'h0560, 16'h00f7);
		rd(16'h0560, 16'h00f7);
		rd(16'h0001, 16'h0000);
		`CHK("par_err_o", 1'b1, par_err_o)
	endtask
	// fast rate through soft reset; parity none stays pending, line keeps even
	task t_setup;
		wr(16'h000a, 16'h0006);
		wr(16'h0022, 16'h007b);
		wr(16'h055f, 16'h0002);
		rd(16'h055f, 16'h0002);
		wr(16'h0560, 16'h0005);
		wr(16'h018b, 16'h0002);
		repeat (2) @(negedge clk_i);
		`CHK("modbus_on_o", 1'b1, modbus_on_o)
		repeat (40 * 174) @(negedge clk_i);
	endtask
	task t_uni;
		req(8'h05, 1'b0);
		`CHK("req_words", 3, q.size())
		`CHK("req_first", 10'h005, q[0])
		`CHK("req_marker", 10'h300, q[2])
		`CHK("resp_pending_o", 1'b1, resp_pending_o)
		reply(8'h05, 1'b0);
		reply(8'ha5, 1'b1);
		repeat (12 * 174) @(negedge clk_i);
		`CHK("reply_chars", 8'h02, char_cnt)
		`CHK("reply_last", 8'ha5, last_byte)
		`CHK("resp_pending_o", 1'b0, resp_pending_o)
	endtask
	task t_bcast;
		req(8'h00, 1'b0);
		`CHK("bcast_marker", 10'h301, q[2])
		`CHK("resp_pending_o", 1'b0, resp_pending_o)
		`CHK("reply_chars", 8'h02, char_cnt)
	endtask
	// frame for another slave, then an unowed reply byte is swallowed
	task t_foreign;
		req(8'h09, 1'b0);
		`CHK("req_words", 0, q.size())
		reply(8'h11, 1'b1);
		repeat (20) @(negedge clk_i);
		`CHK("reply_chars", 8'h02, char_cnt)
	endtask
	task t_bad;
		req(8'h05, 1'b1);
		`CHK("bad_marker", 10'h200, q[2])
		`CHK("resp_pending_o", 1'b0, resp_pending_o)
	endtask
	// ascii frame ":0506" then line feed; the two address digits go out first
	task t_ascii;
		wr(16'h018b, 16'h0003);
		q.delete();
		msp_port_master_inst.send7(7'h3a);
		msp_port_master_inst.send7(7'h30);
		msp_port_master_inst.send7(7'h35);
		msp_port_master_inst.send7(7'h30);
		msp_port_master_inst.send7(7'h36);
		msp_port_master_inst.send7(7'h0a);
		repeat (20) @(negedge clk_i);
		`CHK("asc_words", 5, q.size())
		`CHK("asc_first", 10'h030, q[0])
		`CHK("asc_marker", 10'h300, q[4])
		`CHK("resp_pending_o", 1'b1, resp_pending_o)
		reply(8'h3a, 1'b1);
		repeat (12 * 174) @(negedge clk_i);
		`CHK("reply_chars", 8'h03, char_cnt)
	endtask
	task t_off;
		wr(16'h018b, 16'h0000);
		repeat (2) @(negedge clk_i);
		`CHK("modbus_on_o", 1'b0, modbus_on_o)
		req(8'h05, 1'b0);
		`CHK("req_words", 0, q.size())
	endtask

	initial begin
		repeat (16) @(negedge clk_i);
		rst_b_i = 1;
		t_regs;
		t_setup;
		t_uni;
		t_bcast;
		t_foreign;
		t_bad;
		t_ascii;
		t_off;
		summarize;
	end
endmodule
